// [csa_ctrl.sv]
// Control serial port, auxiliary DAC control and auxiliary conversion sequencer.
// Notes on behaviour
// - Serial clock and data are ignored while frame enable is high.
// - A frame is 21 bits, MSB first: dummy, 12 data, register, device address.
// - Bits 3..0 device, 7..4 register, 19..8 data, bit 20 dummy.
// - Input sampled on rising serial clock, output changed on falling serial clock.
// - Device address 1001 loads data into addressed register at frame enable rise.
// - Read is two frames: request write, then data shifted out next frame.
// - Ramp curve written into 64x10 RAM; only 48 entries reachable.
// - Gain DAC powered only with standby high and its power-up bit set.
// - Gain DAC write activates it with new code; powered down after reset.
// - Frequency DAC code resets to 800H and is on after reset, subject to standby.
// - Ramp DAC is off after reset.
// - Five 12-bit result registers: input 1 transmit, input 1 other, inputs 2..4.
// - Result read returns contents and schedules a new measurement.
// - Read request sets channel pending flag; cleared when conversion completes.
// - Non-transmit channels convert only while receive burst is low, after settling.
// - Receive burst rising aborts a conversion; restarted once it falls again.
// - Transmit channel waits transmit burst rise, settles plus delay times 48 clocks.
// - Multiplexer routes the selected input onto the receive converter.
// - Read request at address 0000: data 7..4 target, 3..0 subaddress.
// - Gain DAC value register holds 8 bits, reset value 85H.
// - Result registers read-only at 0101..1001 in channel order.
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps

module csa_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_clock_i,
  input wire logic frame_enable_n_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  input wire logic aux_standby_in_i,
  input wire logic rx_burst_active_i,
  input wire logic tx_burst_active_i,
  input wire logic [11:0] adc_data_i,
  output logic [2:0] adc_mux_sel_o,
  output logic rx_path_pwr_o,
  output logic [7:0] gain_dac_code_o,
  output logic gain_dac_pwr_o,
  output logic [11:0] freq_dac_code_o,
  output logic freq_dac_pwr_o,
  output logic ramp_dac_pwr_o,
  input wire logic [5:0] ramp_idx_i,
  output logic [9:0] ramp_dac_code_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  logic sclk_d_r;
  logic fen_d_r;
  logic tx_d_r;
  wire logic [5:0] async_in = {tx_burst_active_i, rx_burst_active_i, aux_standby_in_i,
                               serial_data_in_i, frame_enable_n_i, serial_clock_i};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          // Each flop resets to its pin's idle level, so no false edge follows reset.
          meta_r[gi] <= csa_pkg::SYNC_RST[gi];
          sync_r[gi] <= csa_pkg::SYNC_RST[gi];
        end else begin
          meta_r[gi] <= async_in[gi];
          sync_r[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

  wire logic sclk_q = sync_r[0];
  wire logic fen_q = sync_r[1];
  wire logic sdi_q = sync_r[2];
  wire logic stby_q = sync_r[3];
  wire logic rx_q = sync_r[4];
  wire logic tx_q = sync_r[5];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_r <= 1'b0;
      fen_d_r <= 1'b1;
      tx_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_q;
      fen_d_r <= fen_q;
      tx_d_r <= tx_q;
    end
  end

  wire logic frame_act = ~fen_q;
  wire logic sclk_rise = sclk_q & ~sclk_d_r;
  wire logic sclk_fall = ~sclk_q & sclk_d_r;
  wire logic fen_rise = fen_q & ~fen_d_r;
  wire logic fen_fall = ~fen_q & fen_d_r;
  wire logic tx_rise = tx_q & ~tx_d_r;

  // ----------------------------------------------------------------
  // Serial receive
  // ----------------------------------------------------------------
  logic [20:0] shift_r;
  logic [4:0] bit_cnt_r;
  csa_pkg::csa_frame_type frm;
  assign frm = shift_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || fen_rise) begin
      shift_r <= 21'h00_0000;
      bit_cnt_r <= 5'h00;
    end else if (frame_act && sclk_rise) begin
      shift_r <= {shift_r[19:0], sdi_q};
      if (bit_cnt_r != 5'h1F) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // A frame with any other bit count is dropped whole.
  wire logic wr_fire = fen_rise && (bit_cnt_r == csa_pkg::FRAME_BITS) &&
                       (frm.dev_addr_field == csa_pkg::CHIP_ADDR);
  wire logic [3:0] wr_ra = frm.reg_addr_field;
  wire logic [11:0] wr_data = frm.data_field;
  wire logic wr_req = wr_fire && (wr_ra == csa_pkg::RA_READ_REQ);
  wire logic wr_gain = wr_fire && (wr_ra == csa_pkg::RA_GAIN);
  wire logic wr_freq = wr_fire && (wr_ra == csa_pkg::RA_FREQ);
  wire logic wr_burst = wr_fire && (wr_ra == csa_pkg::RA_BURST);

  // ----------------------------------------------------------------
  // Register block
  // ----------------------------------------------------------------
  logic [7:0] gain_code_r;
  logic gain_act_r;
  logic [11:0] freq_code_r;
  logic [2:0] ctrl_r;
  logic [11:0] delay_r;
  logic [4:0] pend_r;
  logic [11:0] res_r [csa_pkg::NUM_CH];
  logic rd_pend_r;
  logic [3:0] rd_tgt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_code_r <= csa_pkg::GAIN_RST;
      gain_act_r <= 1'b0;
      freq_code_r <= csa_pkg::FREQ_RST;
    end else begin
      if (wr_gain) begin
        gain_code_r <= wr_data[7:0];
        gain_act_r <= 1'b1;
      end
      if (wr_freq) begin
        freq_code_r <= wr_data;
      end
    end
  end

  assign gain_dac_code_o = gain_code_r;
  assign freq_dac_code_o = freq_code_r;
  assign gain_dac_pwr_o = stby_q & ctrl_r[csa_pkg::CTRL_GAIN_PWR_BIT] & gain_act_r;
  assign freq_dac_pwr_o = stby_q & ctrl_r[csa_pkg::CTRL_FREQ_PWR_BIT];
  assign ramp_dac_pwr_o = ctrl_r[csa_pkg::CTRL_RAMP_ON_BIT];

  // ----------------------------------------------------------------
  // Ramp curve RAM
  // ----------------------------------------------------------------
  localparam int RAM_DEPTH_L = csa_pkg::RAM_DEPTH;
  logic [9:0] ramp_mem [RAM_DEPTH_L];
  logic [5:0] ram_addr_r;
  wire logic ram_set = wr_burst && (wr_data[11:8] == csa_pkg::SUB_RAM_ADDR);
  wire logic ram_data = wr_burst && (wr_data[11:10] == csa_pkg::SUB_RAM_DATA);
  wire logic ram_we = ram_data && (ram_addr_r < csa_pkg::RAM_USABLE);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ram_addr_r <= 6'h00;
    end else if (ram_set) begin
      ram_addr_r <= wr_data[5:0];
    end else if (ram_we) begin
      ram_addr_r <= ram_addr_r + 6'h01;
    end
  end

  // The RAM keeps no reset so it maps onto plain storage cells.
  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      ramp_mem[ram_addr_r] <= wr_data[9:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_dac_code_o <= 10'h000;
    end else begin
      ramp_dac_code_o <= ramp_mem[ramp_idx_i];
    end
  end

  // ----------------------------------------------------------------
  // Read request and serial transmit
  // ----------------------------------------------------------------
  wire logic [3:0] req_tgt = wr_data[7:4];
  wire logic req_res = (req_tgt >= csa_pkg::RA_RES_FIRST) && (req_tgt <= csa_pkg::RA_RES_LAST);
  wire logic [2:0] req_ch = 3'(req_tgt - csa_pkg::RA_RES_FIRST);
  wire logic [4:0] req_set = (wr_req && req_res) ? 5'(5'h01 << req_ch) : 5'h00;
  wire logic tgt_res = (rd_tgt_r >= csa_pkg::RA_RES_FIRST) &&
                       (rd_tgt_r <= csa_pkg::RA_RES_LAST);
  wire logic [2:0] tgt_ch = 3'(rd_tgt_r - csa_pkg::RA_RES_FIRST);
  wire logic [11:0] rd_data = (rd_tgt_r == csa_pkg::RA_GAIN) ? {4'h0, gain_code_r} :
                              (rd_tgt_r == csa_pkg::RA_FREQ) ? freq_code_r :
                              (rd_tgt_r == csa_pkg::RA_ADC_CTRL) ? {7'h00, pend_r} :
                              tgt_res ? res_r[tgt_ch] : 12'h000;
  logic [20:0] out_sh_r;
  logic rd_act_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_pend_r <= 1'b0;
      rd_tgt_r <= 4'h0;
      rd_act_r <= 1'b0;
      out_sh_r <= 21'h00_0000;
    end else begin
      if (wr_req) begin
        rd_pend_r <= 1'b1;
        rd_tgt_r <= req_tgt;
      end else if (fen_fall && rd_pend_r) begin
        rd_pend_r <= 1'b0;
      end
      if (fen_fall && rd_pend_r) begin
        rd_act_r <= 1'b1;
        out_sh_r <= {1'b0, rd_data, rd_tgt_r, csa_pkg::CHIP_ADDR};
      end else if (fen_rise) begin
        rd_act_r <= 1'b0;
      end else if (frame_act && sclk_fall && bit_cnt_r != 5'h00) begin
        out_sh_r <= {out_sh_r[19:0], 1'b0};
      end
    end
  end

  assign serial_data_out_o = out_sh_r[20];
  assign serial_data_out_oe_o = rd_act_r & frame_act;

  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  csa_pkg::csa_state_type st_r;
  logic [2:0] chan_r;
  logic [11:0] cnt_r;
  logic [5:0] pre_r;
  logic [11:0] unit_r;
  // Receive-slot channels go first, but once a transmit-slot request enters ST_WAIT_TX they wait for the transmit burst rise.
  wire logic [2:0] next_ch = pend_r[1] ? 3'h1 : pend_r[2] ? 3'h2 : pend_r[3] ? 3'h3 :
                             pend_r[4] ? 3'h4 : 3'h0;
  wire logic rx_free = |pend_r[4:1] && !rx_q;
  wire logic settled = (st_r == csa_pkg::ST_SETTLE) && (cnt_r == csa_pkg::SETTLE_LAST);
  wire logic unit_end = pre_r == csa_pkg::DELAY_UNIT_LAST;
  wire logic abort = (st_r == csa_pkg::ST_SETTLE) && (chan_r != 3'h0) && rx_q;
  wire logic done = stby_q && !abort &&
                    ((settled && (chan_r != 3'h0 || delay_r == 12'h000)) ||
                     ((st_r == csa_pkg::ST_DELAY) && unit_end && unit_r == delay_r - 12'h001));
  wire logic [4:0] clr_vec = done ? 5'(5'h01 << chan_r) : 5'h00;

  // A request landing in the completion cycle keeps its flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 5'h00;
    end else begin
      pend_r <= (pend_r & ~clr_vec) | req_set;
    end
  end

  // The sequencer holds while standby is low, as the master clock is then off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= csa_pkg::ST_IDLE;
      chan_r <= 3'h0;
      cnt_r <= 12'h000;
      pre_r <= 6'h00;
      unit_r <= 12'h000;
    end else if (stby_q) begin
      case (st_r)
        csa_pkg::ST_IDLE: begin
          cnt_r <= 12'h000;
          pre_r <= 6'h00;
          unit_r <= 12'h000;
          if (rx_free) begin
            chan_r <= next_ch;
            st_r <= csa_pkg::ST_SETTLE;
          end else if (pend_r[0]) begin
            chan_r <= 3'h0;
            st_r <= csa_pkg::ST_WAIT_TX;
          end
        end
        csa_pkg::ST_WAIT_TX: begin
          if (tx_rise) begin
            st_r <= csa_pkg::ST_SETTLE;
          end
        end
        csa_pkg::ST_SETTLE: begin
          cnt_r <= cnt_r + 12'h001;
          if (abort || done) begin
            st_r <= csa_pkg::ST_IDLE;
          end else if (settled) begin
            st_r <= csa_pkg::ST_DELAY;
          end
        end
        csa_pkg::ST_DELAY: begin
          pre_r <= unit_end ? 6'h00 : pre_r + 6'h01;
          if (unit_end) begin
            unit_r <= unit_r + 12'h001;
          end
          if (done) begin
            st_r <= csa_pkg::ST_IDLE;
          end
        end
        default: begin
          st_r <= csa_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < csa_pkg::NUM_CH; i++) begin
        res_r[i] <= 12'h000;
      end
    end else if (done) begin
      res_r[chan_r] <= adc_data_i;
    end
  end

  assign rx_path_pwr_o = (st_r == csa_pkg::ST_SETTLE) || (st_r == csa_pkg::ST_DELAY);
  assign adc_mux_sel_o = chan_r;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  logic ack_r;
  logic [31:0] rdat_r;
  wire logic wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire logic hit_ctrl = wb_adr_i == csa_pkg::WB_CTRL;
  wire logic hit_delay = wb_adr_i == csa_pkg::WB_DELAY;
  wire logic hit_stat = wb_adr_i == csa_pkg::WB_STATUS;
  wire logic wb_wr = wb_req & wb_we_i;
  wire logic [31:0] rd_mux = hit_ctrl ? {29'h0000_0000, ctrl_r} :
                             hit_delay ? {20'h0_0000, delay_r} :
                             hit_stat ? {25'h000_0000, rd_pend_r, st_r != csa_pkg::ST_IDLE, pend_r} :
                             32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      ctrl_r <= csa_pkg::CTRL_RST;
      delay_r <= csa_pkg::DELAY_RST;
    end else begin
      ack_r <= wb_req;
      rdat_r <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      if (wb_wr && hit_ctrl && wb_sel_i[0]) begin
        ctrl_r <= wb_dat_i[2:0];
      end
      if (wb_wr && hit_delay && wb_sel_i[0]) begin
        delay_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_wr && hit_delay && wb_sel_i[1]) begin
        delay_r[11:8] <= wb_dat_i[11:8];
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_idle_frame_hold: assert property (!frame_act && !fen_rise && sclk_rise |=> $stable(shift_r))
    else $error("shift register moved outside a frame");
  a_msb_first_shift: assert property (frame_act && sclk_rise |=> shift_r == {$past(shift_r[19:0]), $past(sdi_q)})
    else $error("serial bit not shifted in at the low end");
  a_gain_write_load: assert property (wr_gain |=> gain_code_r == $past(wr_data[7:0]) && gain_act_r)
    else $error("gain register not loaded from frame");
  a_sdo_fall_only: assert property (rd_act_r && frame_act && !sclk_fall |=> $stable(serial_data_out_o))
    else $error("serial output changed off a falling edge");
  a_sdo_release: assert property (!frame_act |-> !serial_data_out_oe_o)
    else $error("serial output driven outside a frame");
  a_gain_pwr_gate: assert property (gain_dac_pwr_o |-> stby_q && ctrl_r[csa_pkg::CTRL_GAIN_PWR_BIT])
    else $error("gain DAC powered without standby and power-up bit");
  a_flag_set: assert property (req_set != 5'h00 |=> (pend_r & $past(req_set)) == $past(req_set))
    else $error("read request did not set its pending flag");
  a_rx_abort: assert property (abort && stby_q |=> st_r == csa_pkg::ST_IDLE && pend_r[$past(chan_r)])
    else $error("conversion not aborted on receive burst");
  a_ram_range: assert property (ram_we |-> ram_addr_r < csa_pkg::RAM_USABLE)
    else $error("ramp RAM written beyond usable range");
  a_mux_route: assert property (rx_path_pwr_o && $past(rx_path_pwr_o) |-> $stable(adc_mux_sel_o))
    else $error("multiplexer moved during a conversion");
  a_rx_start_low: assert property ($rose(rx_path_pwr_o) && chan_r != 3'h0 |-> !$past(rx_q))
    else $error("conversion started during receive burst");

  c_serial_write: cover property (wr_fire);
  c_read_frame: cover property (fen_fall && rd_pend_r);
  c_conv_done: cover property (done);
  c_conv_abort: cover property (abort);

endmodule

// [csa_pkg.sv]
// Shared constants and types for the control serial port with auxiliary converter sequencing.
package csa_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int AUX_CONV_SETTLE_TIME_NS = 20000;
  localparam int SETTLE_CYC = (AUX_CONV_SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYC - 1);
  localparam logic [5:0] DELAY_UNIT_LAST = 6'h2F;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam logic [4:0] FRAME_BITS = 5'h15;
  localparam logic [3:0] CHIP_ADDR = 4'h9;
  localparam logic [3:0] RA_READ_REQ = 4'h0;
  localparam logic [3:0] RA_GAIN = 4'h1;
  localparam logic [3:0] RA_FREQ = 4'h2;
  localparam logic [3:0] RA_BURST = 4'h3;
  localparam logic [3:0] RA_ADC_CTRL = 4'h4;
  localparam logic [3:0] RA_RES_FIRST = 4'h5;
  localparam logic [3:0] RA_RES_LAST = 4'h9;
  localparam logic [7:0] GAIN_RST = 8'h85;
  localparam logic [11:0] FREQ_RST = 12'h800;
  localparam logic [3:0] SUB_RAM_ADDR = 4'hB;
  localparam logic [1:0] SUB_RAM_DATA = 2'h3;
  localparam logic [5:0] RAM_USABLE = 6'h30;
  localparam int RAM_DEPTH = 64;
  localparam int NUM_CH = 5;
  // Idle levels of the synchronised pins: frame enable idles high, the rest low.
  localparam logic [5:0] SYNC_RST = 6'h02;

  typedef struct packed {
    logic dummy;
    logic [11:0] data_field;
    logic [3:0] reg_addr_field;
    logic [3:0] dev_addr_field;
  } csa_frame_type;

  // ----------------------------------------------------------------
  // Bus registers
  // ----------------------------------------------------------------
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_DELAY = 8'h04;
  localparam logic [7:0] WB_STATUS = 8'h08;
  localparam int CTRL_GAIN_PWR_BIT = 0;
  localparam int CTRL_FREQ_PWR_BIT = 1;
  localparam int CTRL_RAMP_ON_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [11:0] DELAY_RST = 12'h000;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TX, ST_SETTLE, ST_DELAY} csa_state_type;

endpackage

// [csa_sctl_model.sv]
// Behavioural baseband controller that drives the control serial link.
`timescale 1ns/1ps
module csa_sctl_model (
  input wire logic clk_i,
  input wire logic serial_data_out_i,
  input wire logic serial_data_out_oe_i,
  output logic serial_clock_o,
  output logic frame_enable_n_o,
  output logic serial_data_in_o
);
  initial begin
    serial_clock_o = 1'b0;
    frame_enable_n_o = 1'b1;
    serial_data_in_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // One framed word
  // ----------------------------------------------------------------
  // The link clock is 85 ns and stands low between frames.
  // The data line is inverted after the frame so a stale bit never reads as valid.
  task automatic xfer(input logic [20:0] w, output logic [20:0] r, output logic oe_ok);
    oe_ok = 1'b1;
    @(posedge clk_i);
    frame_enable_n_o <= 1'b0;
    for (int i = 20; i >= 0; i--) begin
      @(posedge clk_i);
      serial_data_in_o <= w[i];
      repeat (8) @(posedge clk_i);
      // A released output line reads as the inverse of its last bit, so a missing enable shows.
      r[i] = serial_data_out_oe_i ? serial_data_out_i : ~serial_data_out_i;
      oe_ok = oe_ok & (serial_data_out_oe_i === 1'b1);
      serial_clock_o <= 1'b1;
      repeat (8) @(posedge clk_i);
      serial_clock_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    frame_enable_n_o <= 1'b1;
    serial_data_in_o <= ~w[0];
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// [tb.sv]
// Self-checking testbench for the control serial port and auxiliary sequencer.
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i, cyc, stb, we, stby, rx_burst_active, tx_burst_active, sclk, fen_n, sdi, sdo, oe;
  logic rx_pwr, gain_pwr, freq_pwr, ramp_pwr, ok, ack;
  logic [5:0] ridx;
  logic [9:0] rcode;
  logic [7:0] adr, gain_code;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [11:0] adc, freq_code;
  logic [2:0] mux;
  logic [20:0] r;
  int err_total, cmp_count, n;

  csa_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_clock_i(sclk), .frame_enable_n_i(fen_n), .serial_data_in_i(sdi),
    .serial_data_out_o(sdo), .serial_data_out_oe_o(oe), .aux_standby_in_i(stby),
    .rx_burst_active_i(rx_burst_active), .tx_burst_active_i(tx_burst_active), .adc_data_i(adc),
    .adc_mux_sel_o(mux), .rx_path_pwr_o(rx_pwr), .gain_dac_code_o(gain_code),
    .gain_dac_pwr_o(gain_pwr), .freq_dac_code_o(freq_code), .freq_dac_pwr_o(freq_pwr),
    .ramp_dac_pwr_o(ramp_pwr), .ramp_idx_i(ridx), .ramp_dac_code_o(rcode));

  csa_sctl_model m (.clk_i(clk_i), .serial_data_out_i(sdo), .serial_data_out_oe_i(oe),
    .serial_clock_o(sclk), .frame_enable_n_o(fen_n), .serial_data_in_o(sdi));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  function automatic logic [20:0] fw(logic [3:0] ra, logic [11:0] d, logic [3:0] da);
    return {1'b0, d, ra, da};
  endfunction

  task automatic wr_s(input logic [3:0] ra, input logic [11:0] d);
    m.xfer(fw(ra, d, csa_pkg::CHIP_ADDR), r, ok);
  endtask

  // The second frame goes to another device, so it only collects the answer.
  task automatic rd_s(input logic [3:0] ra);
    wr_s(csa_pkg::RA_READ_REQ, {4'h0, ra, 4'h0});
    m.xfer(fw(4'h0, 12'h000, 4'h0), r, ok);
  endtask

  task automatic wait_pwr(input logic lvl, input int lim);
    n = 0;
    while (rx_pwr !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(rx_pwr, lvl, "receive path power");
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    {cyc, stb, we, stby, rx_burst_active, tx_burst_active} = 6'h00;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    adc = 12'h5A5;
    ridx = 6'h00;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(gain_code, csa_pkg::GAIN_RST, "gain code");
    chk(gain_pwr, 1'b0, "gain power");
    chk(freq_code, csa_pkg::FREQ_RST, "freq code");
    chk(ramp_pwr, 1'b0, "ramp power");
    chk(oe, 1'b0, "output enable");
    wb(csa_pkg::WB_CTRL, 1'b0, 32'h0000_0000);
    chk(q, {29'h0, csa_pkg::CTRL_RST}, "ctrl reset");
    wb(8'h0C, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000, "unmapped read");
    stby <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(freq_pwr, 1'b1, "freq power");
    wb(csa_pkg::WB_CTRL, 1'b1, 32'h0000_0007);
    repeat (2) @(posedge clk_i);
    chk(ramp_pwr, 1'b1, "ramp power on");
    chk(gain_pwr, 1'b0, "gain power before write");
    wr_s(csa_pkg::RA_GAIN, 12'h03C);
    chk(gain_code, 8'h3C, "gain code");
    chk(gain_pwr, 1'b1, "gain power");
    m.xfer(fw(csa_pkg::RA_GAIN, 12'h0C3, 4'h6), r, ok);
    chk(gain_code, 8'h3C, "foreign device");
    wr_s(csa_pkg::RA_FREQ, 12'hABC);
    chk(freq_code, 12'hABC, "freq code");
    rd_s(csa_pkg::RA_FREQ);
    chk(r, {1'b0, 12'hABC, csa_pkg::RA_FREQ, csa_pkg::CHIP_ADDR}, "read frame");
    chk(ok, 1'b1, "enable during read");
    chk(oe, 1'b0, "enable after frame");
    wr_s(csa_pkg::RA_BURST, 12'hB2F);
    wr_s(csa_pkg::RA_BURST, 12'hEA5);
    ridx <= 6'h2F;
    repeat (3) @(posedge clk_i);
    chk(rcode, 10'h2A5, "ramp word");
    stby <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(gain_pwr, 1'b0, "gain standby");
    chk(freq_pwr, 1'b0, "freq standby");
    stby <= 1'b1;
    repeat (4) @(posedge clk_i);
    wr_s(csa_pkg::RA_READ_REQ, 12'h060);
    wb(csa_pkg::WB_STATUS, 1'b0, 32'h0000_0000);
    chk(q[4:0], 5'h02, "pending flag");
    wait_pwr(1'b1, 20);
    chk(mux, 3'd1, "mux select");
    repeat (100) @(posedge clk_i);
    rx_burst_active <= 1'b1;
    wait_pwr(1'b0, 10);
    repeat (50) @(posedge clk_i);
    chk(rx_pwr, 1'b0, "held off by burst");
    rx_burst_active <= 1'b0;
    wait_pwr(1'b1, 20);
    wait_pwr(1'b0, csa_pkg::SETTLE_CYC + 20);
    wb(csa_pkg::WB_STATUS, 1'b0, 32'h0000_0000);
    chk(q[1], 1'b0, "pending cleared");
    rd_s(4'h6);
    chk(r, {1'b0, 12'h5A5, 4'h6, csa_pkg::CHIP_ADDR}, "result frame");
    wait_pwr(1'b1, 40);
    wait_pwr(1'b0, csa_pkg::SETTLE_CYC + 20);
    wb(csa_pkg::WB_DELAY, 1'b1, 32'h0000_0002);
    wr_s(csa_pkg::RA_READ_REQ, 12'h050);
    repeat (100) @(posedge clk_i);
    chk(rx_pwr, 1'b0, "waits for transmit burst");
    tx_burst_active <= 1'b1;
    wait_pwr(1'b1, 20);
    chk(mux, 3'd0, "mux select tx");
    n = 0;
    while (rx_pwr === 1'b1 && n < 6000) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, n >= csa_pkg::SETTLE_CYC + 96 && n <= csa_pkg::SETTLE_CYC + 106},
      32'h1, "tx conversion span");
    tx_burst_active <= 1'b0;
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    $display("FAIL %0t watchdog expired", $time);
    test_done();
  end
endmodule
